// >>> common/clock_gen_pkg.sv
/*
  Shared constants and carriers for the clock generator control and status block.
  Assumes a 32-bit Avalon-MM register bus with byte addresses and a single 50 MHz clock.
*/
package clock_gen_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
  localparam logic [7:0] OFS_STATUS_ONE  = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h0C;
  localparam logic [7:0] OFS_MODE_REQ    = 8'h10;

  // Status register one bit positions.
  localparam int STS_MODE_LSB   = 6;
  localparam int STS_REF_BIT    = 5;
  localparam int STS_LOL_BIT    = 4;
  localparam int STS_LOCK_BIT   = 3;
  localparam int STS_LOC_BIT    = 2;
  localparam int STS_EXTV_BIT   = 1;
  localparam int STS_IRQF_BIT   = 0;

  // Interrupt status and mask bit positions.
  localparam int IRQ_LOL_BIT    = 0;
  localparam int IRQ_LOC_BIT    = 1;
  localparam int IRQ_MODE_BIT   = 2;
  localparam int IRQ_UPD_BIT    = 3;
  localparam int IRQ_W          = 4;

  // Reset values.
  localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
  localparam logic [1:0] MODE_RST        = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 4'h0;

  // Time a field update takes to complete inside the generator.
  localparam int CLK_PERIOD_NS   = 20;
  localparam int UPDATE_TIME_NS  = 200;
  localparam int UPDATE_CYCLES   = (UPDATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Clock modes as reported in status bits 7:6.
  localparam logic [1:0] MODE_SELF_CLOCKED = 2'h0;
  localparam logic [1:0] MODE_ENGAGED_INT  = 2'h1;
  localparam logic [1:0] MODE_BYPASS_EXT   = 2'h2;
  localparam logic [1:0] MODE_ENGAGED_EXT  = 2'h3;

  // Control register two layout.
  typedef struct packed {
    logic       lock_loss_reset_enable;
    logic [2:0] loop_multiplier_field;
    logic       clock_loss_reset_enable;
    logic [2:0] output_divider_field;
  } control_two_t;

  // Status reported by the generator core.
  typedef struct packed {
    logic loop_locked;
    logic lock_lost;
    logic clock_lost;
    logic ext_reference_valid;
    logic reference_choice;
    logic off_mode;
  } core_status_t;

  // Settings applied to the generator core.
  typedef struct packed {
    logic [4:0] loop_factor;
    logic [7:0] divide_factor;
    logic [1:0] clock_mode;
  } core_setting_t;

endpackage

// >>> design/mode_sync.sv
/*
  Carries the clock mode request across to the generator side and reports the mode
  once it has settled. Assumes the request is held stable for several cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module mode_sync (
  input  wire logic       mclk_in,     // System clock.
  input  wire logic       rst_in,      // Synchronous reset, active high.
  input  wire logic [1:0] request_in,  // Requested clock mode.
  output logic      [1:0] mode_out,    // Settled clock mode.
  output logic            changed_out  // One-cycle pulse when the mode changes.
);
  import clock_gen_pkg::*;

  logic [1:0] stage_one;
  logic [1:0] stage_two;
  logic [1:0] stage_three;

  // Three stages; only the later two are compared so the first stage feeds nothing else.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stage_one   <= MODE_RST;
      stage_two   <= MODE_RST;
      stage_three <= MODE_RST;
    end else begin
      stage_one   <= request_in;
      stage_two   <= stage_one;
      stage_three <= stage_two;
    end
  end

  // Report moves only once two later stages agree, so a half-changed pair never shows.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_out    <= MODE_RST;
      changed_out <= 1'b0;
    end else begin
      changed_out <= 1'b0;
      if (stage_two == stage_three && stage_three != mode_out) begin
        mode_out    <= stage_three;
        changed_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/clock_gen_ctrl_status.sv
/*
  Control register two and status register one of the internal clock generator, with
  an Avalon-MM slave, an event interrupt block and the update timing of the factors.
  Assumes the core status inputs are synchronous to mclk_in and event inputs are pulses.
  A new factor reaches the core only UPDATE_CYC cycles after the write that set it.
*/
// Design decisions made here: the register addresses and the Avalon-MM register port.
// Overview of operation
// - Lock loss gives interrupt when its reset enable is 0, reset request when 1.
// - Multiplier field codes 0 to 6 decode to factors 4,6,8,10,12,14,18.
// - Multiplier field writes are ignored while its previous update completes.
// - Clock loss gives interrupt when its reset enable is 0, reset request when 1.
// - Divider field value v gives output division factor two to the power v.
// - Divider field writes are ignored while its previous update completes.
// - Status bits 7:6 report the active clock mode.
// - Reported mode follows the request only after synchronization.
// - Status bit 5 reports the chosen reference, 1 for crystal or resonator.
// - Lock loss sets a sticky flag at bit 4 held until cleared.
// - Status bit 3 shows lock, forced 0 in off, self-clocked and bypass modes.
// - Clock loss sets a sticky flag held until cleared.
// - Status bit 1 shows the external reference is stable and fast enough.
// - Interrupt flag at bit 0 is set while a request pends, cleared on reset.
// - Flag clears only after a status read with flag set, then writing 1.
// - A new event during the clear sequence restarts it, leaving the flag set.
// - Writing 0 to the interrupt flag leaves it unchanged.
`timescale 1ns/1ns
`default_nettype none
module clock_gen_ctrl_status #(
  parameter int UPDATE_CYC = clock_gen_pkg::UPDATE_CYCLES  // Cycles a factor update takes.
) (
  input  wire logic                         mclk_in,          // System clock.
  input  wire logic                         rst_in,           // Synchronous reset, active high.
  input  wire logic [7:0]                   avs_address_in,   // Avalon byte address.
  input  wire logic                         avs_read_in,      // Avalon read request.
  input  wire logic                         avs_write_in,     // Avalon write request.
  input  wire logic [31:0]                  avs_writedata_in, // Avalon write data.
  input  wire logic [3:0]                   avs_byteenable_in,// Avalon byte enables.
  output logic      [31:0]                  avs_readdata_out, // Avalon read data.
  output logic                              avs_waitrequest_out, // Avalon wait request.
  input  wire clock_gen_pkg::core_status_t  core_status_in,   // Generator core status.
  output clock_gen_pkg::core_setting_t      core_setting_out, // Settings to the core.
  output logic                              reset_request_out,// Reset request to the system.
  output logic                              cg_irq_out,       // Generator interrupt request line.
  output logic                              irq_out           // Masked event interrupt.
);
  import clock_gen_pkg::*;

  // The busy counters are eight bits; a longer update would wrap them, and a
  // zero update would open no refusal window at all.
  if (UPDATE_CYC < 1 || UPDATE_CYC > 255) begin : g_check
    $error("UPDATE_CYC must lie between 1 and 255");
  end

  // Load value of the busy counters, cut to their width on purpose.
  localparam logic [7:0] UPD_LOAD = 8'(UPDATE_CYC);

  // Multiplier decode; code 7 is undefined and holds the largest factor.
  // Keeping the loop output in range stays the job of software.
  function automatic logic [4:0] decode_mult(input logic [2:0] code);
    unique case (code)
      3'h0: decode_mult = 5'h04;
      3'h1: decode_mult = 5'h06;
      3'h2: decode_mult = 5'h08;
      3'h3: decode_mult = 5'h0A;
      3'h4: decode_mult = 5'h0C;
      3'h5: decode_mult = 5'h0E;
      3'h6: decode_mult = 5'h12;
      3'h7: decode_mult = 5'h12;
    endcase
  endfunction

  // Divider decode is a plain power of two.
  // A shift of at most seven stays inside eight bits.
  function automatic logic [7:0] decode_div(input logic [2:0] code);
    decode_div = 8'h01 << code;
  endfunction

  // Register state, event flags and update timers.
  control_two_t control_two;
  logic [1:0]   mode_request;
  logic [1:0]   mode_report;
  logic         mode_changed;
  logic         lock_loss_sticky_flag;
  logic         clock_loss_sticky_flag;
  logic         clock_gen_irq_flag;
  logic         clear_armed;
  logic [7:0]   mult_busy;
  logic [7:0]   div_busy;
  logic         mult_done;
  logic         div_done;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [7:0]   status_one;
  // Bus strobes, valid only in the cycle a request completes, then the event, lock and read mux terms.
  logic         access;
  logic         wr_ok;
  logic         wr_ctrl;
  logic         wr_status;
  logic         rd_status;
  logic         lol_irq_event;
  logic         loc_irq_event;
  logic         irq_event;
  logic         lock_shown;
  logic [31:0]  next_readdata;

  // An access completes at the edge where waitrequest is sampled low.
  // Writes need byte lane zero; the other lanes carry nothing here.
  assign access    = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  assign wr_ok     = access & avs_write_in & avs_byteenable_in[0];
  assign wr_ctrl   = wr_ok && avs_address_in == OFS_CONTROL_TWO;
  assign wr_status = wr_ok && avs_address_in == OFS_STATUS_ONE;
  assign rd_status = access && avs_read_in && avs_address_in == OFS_STATUS_ONE;

  // Events that ask for an interrupt rather than a reset.
  // The pulse drives the request, so an old sticky flag cannot fire again.
  assign lol_irq_event = core_status_in.lock_lost & ~control_two.lock_loss_reset_enable;
  assign loc_irq_event = core_status_in.clock_lost & ~control_two.clock_loss_reset_enable;
  assign irq_event     = lol_irq_event | loc_irq_event;

  // Lock is shown only in the two engaged modes and never while off.
  assign lock_shown = core_status_in.loop_locked & ~core_status_in.off_mode &
                      (mode_report == MODE_ENGAGED_INT || mode_report == MODE_ENGAGED_EXT);

  // Status register one as software sees it.
  // Gathered fresh each cycle; nothing here is stored twice.
  always_comb begin
    status_one                = 8'h00;
    status_one[7:STS_MODE_LSB] = mode_report;
    status_one[STS_REF_BIT]   = core_status_in.reference_choice;
    status_one[STS_LOL_BIT]   = lock_loss_sticky_flag;
    status_one[STS_LOCK_BIT]  = lock_shown;
    status_one[STS_LOC_BIT]   = clock_loss_sticky_flag;
    status_one[STS_EXTV_BIT]  = core_status_in.ext_reference_valid;
    status_one[STS_IRQF_BIT]  = clock_gen_irq_flag;
  end

  // Read mux; unmapped addresses read as zero.
  // Sampled in the wait cycle, while the address still stands.
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address_in)
      OFS_CONTROL_TWO: next_readdata[7:0] = control_two;
      OFS_STATUS_ONE:  next_readdata[7:0] = status_one;
      OFS_IRQ_STATUS:  next_readdata[IRQ_W-1:0] = irq_status;
      OFS_IRQ_MASK:    next_readdata[IRQ_W-1:0] = irq_mask;
      OFS_MODE_REQ:    next_readdata[1:0] = mode_request;
      default:         next_readdata = 32'h0000_0000;
    endcase
  end

  // One wait state on every access keeps read data a registered value.
  // The price is two cycles per access for a clean read path.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      if ((avs_read_in | avs_write_in) && avs_waitrequest_out) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out    <= avs_read_in ? next_readdata : 32'h0000_0000;
      end else begin
        avs_waitrequest_out <= 1'b1;
      end
    end
  end

  // Control register two; each factor field refuses writes while its update runs.
  // The enable bits always land; only a busy field turns the write away.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      control_two <= CONTROL_TWO_RST;
    end else if (wr_ctrl) begin
      control_two.lock_loss_reset_enable  <= avs_writedata_in[7];
      control_two.clock_loss_reset_enable <= avs_writedata_in[3];
      if (mult_busy == 8'h00) begin
        control_two.loop_multiplier_field <= avs_writedata_in[6:4];
      end
      if (div_busy == 8'h00) begin
        control_two.output_divider_field  <= avs_writedata_in[2:0];
      end
    end
  end

  // Update timers; a write that changes a field starts its update.
  // Rewriting the same value opens no refusal window.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mult_busy <= 8'h00;
      div_busy  <= 8'h00;
      mult_done <= 1'b0;
      div_done  <= 1'b0;
    end else begin
      mult_done <= mult_busy == 8'h01;
      div_done  <= div_busy == 8'h01;
      if (mult_busy != 8'h00) begin
        mult_busy <= mult_busy - 8'h01;
      end else if (wr_ctrl && avs_writedata_in[6:4] != control_two.loop_multiplier_field) begin
        mult_busy <= UPD_LOAD;
      end
      if (div_busy != 8'h00) begin
        div_busy <= div_busy - 8'h01;
      end else if (wr_ctrl && avs_writedata_in[2:0] != control_two.output_divider_field) begin
        div_busy <= UPD_LOAD;
      end
    end
  end

  // Factors reach the core only when their update has run its course.
  // The core never sees a factor that is still being changed.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      core_setting_out.loop_factor   <= decode_mult(CONTROL_TWO_RST[6:4]);
      core_setting_out.divide_factor <= decode_div(CONTROL_TWO_RST[2:0]);
      core_setting_out.clock_mode    <= MODE_RST;
    end else begin
      if (mult_busy == 8'h01) begin
        core_setting_out.loop_factor <= decode_mult(control_two.loop_multiplier_field);
      end
      if (div_busy == 8'h01) begin
        core_setting_out.divide_factor <= decode_div(control_two.output_divider_field);
      end
      core_setting_out.clock_mode <= mode_report;
    end
  end

  // Mode request; bypass waits for a valid external reference.
  // The raw request reads back at once; the report lags behind.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_request <= MODE_RST;
    end else if (wr_ok && avs_address_in == OFS_MODE_REQ) begin
      mode_request <= avs_writedata_in[1:0];
    end
  end

  // Bypass without a valid external reference keeps the current mode.
  mode_sync u_mode_sync (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .request_in  ((mode_request == MODE_BYPASS_EXT && !core_status_in.ext_reference_valid) ?
                  mode_report : mode_request),
    .mode_out    (mode_report),
    .changed_out (mode_changed)
  );

  // Sticky loss flags clear by writing one to their bit; a new loss wins over the clear.
  // A reset request rides on these flags until software clears them.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lock_loss_sticky_flag  <= 1'b0;
      clock_loss_sticky_flag <= 1'b0;
    end else begin
      if (core_status_in.lock_lost) begin
        lock_loss_sticky_flag <= 1'b1;
      end else if (wr_status && avs_writedata_in[STS_LOL_BIT]) begin
        lock_loss_sticky_flag <= 1'b0;
      end
      if (core_status_in.clock_lost) begin
        clock_loss_sticky_flag <= 1'b1;
      end else if (wr_status && avs_writedata_in[STS_LOC_BIT]) begin
        clock_loss_sticky_flag <= 1'b0;
      end
    end
  end

  // Interrupt flag with its read-then-write-one clear sequence.
  // A new event disarms, so a clear meant for an older event cannot hide it.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      clock_gen_irq_flag <= 1'b0;
      clear_armed        <= 1'b0;
    end else begin
      if (irq_event) begin
        clock_gen_irq_flag <= 1'b1;
        clear_armed        <= 1'b0;
      end else if (rd_status && clock_gen_irq_flag) begin
        clear_armed <= 1'b1;
      end else if (wr_status && avs_writedata_in[STS_IRQF_BIT] && clear_armed) begin
        clock_gen_irq_flag <= 1'b0;
        clear_armed        <= 1'b0;
      end
    end
  end

  // Writing zero to the flag bit leaves it alone; only the armed write of one clears.
  // Same terms as the flag, so the line never lags it.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cg_irq_out <= 1'b0;
    end else begin
      cg_irq_out <= (clock_gen_irq_flag | irq_event) &
                    ~(wr_status && avs_writedata_in[STS_IRQF_BIT] && clear_armed && !irq_event);
    end
  end

  // Reset request holds while a sticky flag is set with its reset enable high.
  // Clearing the flag or the enable is the only way to end it.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reset_request_out <= 1'b0;
    end else begin
      reset_request_out <= (lock_loss_sticky_flag & control_two.lock_loss_reset_enable) |
                           (clock_loss_sticky_flag & control_two.clock_loss_reset_enable);
    end
  end

  // Event status bits are sticky; a new event wins over a write-one clear.
  // Both factor timers share one update-done bit.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_status <= IRQ_RST;
      irq_mask   <= IRQ_RST;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (wr_ok && avs_address_in == OFS_IRQ_STATUS && avs_writedata_in[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (core_status_in.lock_lost) begin
        irq_status[IRQ_LOL_BIT] <= 1'b1;
      end
      if (core_status_in.clock_lost) begin
        irq_status[IRQ_LOC_BIT] <= 1'b1;
      end
      if (mode_changed) begin
        irq_status[IRQ_MODE_BIT] <= 1'b1;
      end
      if (mult_done | div_done) begin
        irq_status[IRQ_UPD_BIT] <= 1'b1;
      end
      if (wr_ok && avs_address_in == OFS_IRQ_MASK) begin
        irq_mask <= avs_writedata_in[IRQ_W-1:0];
      end
    end
  end

  // Level interrupt from the masked event bits, registered to keep the output clean.
  // A mask change shows one cycle after its write completes.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/clock_gen_ctrl_status_assertions.sv
/*
  Concurrent checks on the ports of the clock generator control and status block.
  Assumes one clock, a synchronous active-high reset and binding from the bench top file.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_gen_ctrl_status_assertions
  import clock_gen_pkg::*;
#(
  parameter int UPDATE_CYC = 2
) (
  input wire logic                          mclk_in,             // System clock.
  input wire logic                          rst_in,              // Synchronous reset.
  input wire logic [7:0]                    avs_address_in,      // Bus address.
  input wire logic                          avs_read_in,         // Bus read.
  input wire logic                          avs_write_in,        // Bus write.
  input wire logic [31:0]                   avs_writedata_in,    // Bus write data.
  input wire logic [3:0]                    avs_byteenable_in,   // Bus byte enables.
  input wire logic                          avs_waitrequest_out, // Bus wait request.
  input wire clock_gen_pkg::core_status_t   core_status_in,      // Core status.
  input wire clock_gen_pkg::core_setting_t  core_setting_out,    // Core settings.
  input wire logic                          reset_request_out,   // Reset request.
  input wire logic                          cg_irq_out           // Generator interrupt.
);
  // Same limits as the bound design, so a bad override shows here too.
  if (UPDATE_CYC < 1 || UPDATE_CYC > 255) begin : g_param_check
    $error("UPDATE_CYC out of range in checker");
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic wr_done;
  logic clr_wr;
  logic lol_en;
  logic loc_en;

  // A write lands at the edge where wait request is low.
  assign wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign clr_wr  = wr_done && avs_address_in == OFS_STATUS_ONE && avs_writedata_in[0];

  // Shadow of the two reset enables, so event checks know which action is due.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lol_en <= 1'b0;
      loc_en <= 1'b0;
    end else if (wr_done && avs_address_in == OFS_CONTROL_TWO) begin
      lol_en <= avs_writedata_in[7];
      loc_en <= avs_writedata_in[3];
    end
  end

  sequence s_lol_event;
    core_status_in.lock_lost;
  endsequence
  sequence s_loc_event;
    core_status_in.clock_lost;
  endsequence

  a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus request not answered next cycle");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait request low for more than one cycle");
  a_wait_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("answer without request");
  a_lol_irq: assert property (s_lol_event and !lol_en |-> ##[1:2] cg_irq_out)
    else $error("lock loss gave no interrupt");
  a_lol_reset: assert property (s_lol_event and lol_en |-> ##[1:3] reset_request_out)
    else $error("lock loss gave no reset request");
  a_loc_irq: assert property (s_loc_event and !loc_en |-> ##[1:2] cg_irq_out)
    else $error("clock loss gave no interrupt");
  a_loc_reset: assert property (s_loc_event and loc_en |-> ##[1:3] reset_request_out)
    else $error("clock loss gave no reset request");
  a_flag_clear: assert property ($fell(cg_irq_out) && !$past(rst_in) |->
                                 $past(clr_wr) || $past(clr_wr, 2))
    else $error("interrupt flag fell without a clearing write");
  a_factor_legal: assert property (core_setting_out.loop_factor inside
                                   {5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h12})
    else $error("illegal loop factor");
  a_divide_pow2: assert property ($onehot(core_setting_out.divide_factor))
    else $error("divide factor not a power of two");
endmodule
`default_nettype wire

// >>> testbench/clock_gen_ctrl_status_tb.sv
/*
  Self-checking bench for the clock generator control and status block.
  Assumes the design package is compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_gen_ctrl_status_tb;
  import clock_gen_pkg::*;
  localparam int UPD = 6;  // Long enough that a back-to-back write lands mid-update.
  logic          mclk_in = 1'b0;
  logic          rst_in = 1'b1;
  logic [7:0]    avs_address_in = 8'h00;
  logic          avs_read_in = 1'b0;
  logic          avs_write_in = 1'b0;
  logic [31:0]   avs_writedata_in = 32'h0;
  logic [3:0]    avs_byteenable_in = 4'hF;
  logic [31:0]   avs_readdata_out;
  logic          avs_waitrequest_out;
  logic          reset_request_out;
  logic          cg_irq_out;
  logic          irq_out;
  core_status_t  core_status_in = '0;
  core_setting_t core_setting_out;
  int            n_fail = 0;
  int            tests_run = 0;
  logic [31:0]   q;
  logic [1:0]    pm;
  logic [4:0]    mult_tab [8] = '{5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h12, 5'h12};

  // Free-running 50 MHz clock.
  always #10 mclk_in = ~mclk_in;

  clock_gen_ctrl_status #(.UPDATE_CYC(UPD)) dut_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .core_status_in(core_status_in), .core_setting_out(core_setting_out),
    .reset_request_out(reset_request_out), .cg_irq_out(cg_irq_out), .irq_out(irq_out)
  );

  task automatic test_done;
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access; the request is held until wait request is sampled low.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_read_in <= !w;
    avs_write_in <= w;
    @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      k++;
      if (k > 20) begin
        n_fail++;
        $display("Error at %0t: no bus answer", $time);
        test_done();
      end
      @(posedge mclk_in);
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hF);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 4'hF);
    chk(q, exp);
  endtask

  // One-cycle loss event pulses, then time for the flags to settle.
  task automatic pulse(input logic lol, input logic loc);
    core_status_in.lock_lost <= lol;
    core_status_in.clock_lost <= loc;
    @(posedge mclk_in);
    core_status_in.lock_lost <= 1'b0;
    core_status_in.clock_lost <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask

  // Main sequence: reset values, factors, modes, interrupt flag and reset requests.
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rdc(OFS_CONTROL_TWO, 32'h0);
    rdc(OFS_STATUS_ONE, 32'h0);
    rdc(OFS_IRQ_MASK, 32'h0);
    wr(8'h1C, 32'hFF);
    rdc(8'h1C, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CONTROL_TWO, {25'h0, c[2:0], 1'b0, c[2:0]});
      repeat (UPD + 4) @(posedge mclk_in);
      chk(core_setting_out.loop_factor, mult_tab[c]);
      chk(core_setting_out.divide_factor, 32'h1 << c);
    end
    wr(OFS_CONTROL_TWO, 32'h22);
    wr(OFS_CONTROL_TWO, 32'h5D);
    rdc(OFS_CONTROL_TWO, 32'h2A);
    repeat (UPD + 4) @(posedge mclk_in);
    chk(core_setting_out.loop_factor, 32'h08);
    chk(core_setting_out.divide_factor, 32'h04);
    acc(1'b1, OFS_CONTROL_TWO, 32'hFF, 4'h0);
    rdc(OFS_CONTROL_TWO, 32'h2A);
    core_status_in <= 6'h26;
    pm = 2'h0;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_MODE_REQ, m);
      chk(core_setting_out.clock_mode, pm);
      repeat (10) @(posedge mclk_in);
      pm = m[1:0];
      chk(core_setting_out.clock_mode, pm);
      rdc(OFS_STATUS_ONE, {24'h0, pm, 2'b10, m[0], 3'b010});
    end
    core_status_in.off_mode <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rdc(OFS_STATUS_ONE, 32'hE2);
    core_status_in <= 6'h00;
    repeat (2) @(posedge mclk_in);
    rdc(OFS_STATUS_ONE, 32'hC0);
    wr(OFS_CONTROL_TWO, 32'h50);
    repeat (UPD + 4) @(posedge mclk_in);
    wr(OFS_IRQ_STATUS, 32'hF);
    rdc(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_IRQ_MASK, 32'h3);
    pulse(1'b1, 1'b0);
    chk(cg_irq_out, 1'b1);
    chk(irq_out, 1'b1);
    chk(reset_request_out, 1'b0);
    wr(OFS_STATUS_ONE, 32'h01);
    chk(cg_irq_out, 1'b1);
    rdc(OFS_STATUS_ONE, 32'hD1);
    wr(OFS_STATUS_ONE, 32'h00);
    chk(cg_irq_out, 1'b1);
    pulse(1'b0, 1'b1);
    wr(OFS_STATUS_ONE, 32'h01);
    chk(cg_irq_out, 1'b1);
    rdc(OFS_STATUS_ONE, 32'hD5);
    wr(OFS_STATUS_ONE, 32'h01);
    repeat (2) @(posedge mclk_in);
    chk(cg_irq_out, 1'b0);
    rdc(OFS_STATUS_ONE, 32'hD4);
    rdc(OFS_IRQ_STATUS, 32'h3);
    wr(OFS_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 1'b0);
    wr(OFS_STATUS_ONE, 32'h14);
    rdc(OFS_STATUS_ONE, 32'hC0);
    wr(OFS_CONTROL_TWO, 32'hD8);
    pulse(1'b1, 1'b0);
    chk(reset_request_out, 1'b1);
    chk(cg_irq_out, 1'b0);
    wr(OFS_STATUS_ONE, 32'h10);
    repeat (2) @(posedge mclk_in);
    chk(reset_request_out, 1'b0);
    pulse(1'b0, 1'b1);
    chk(reset_request_out, 1'b1);
    chk(cg_irq_out, 1'b0);
    test_done();
  end
endmodule

bind clock_gen_ctrl_status clock_gen_ctrl_status_assertions #(.UPDATE_CYC(UPDATE_CYC)) chk_u (
  .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out), .core_status_in(core_status_in),
  .core_setting_out(core_setting_out), .reset_request_out(reset_request_out), .cg_irq_out(cg_irq_out)
);
`default_nettype wire
